// ### logic/epi_pkg.sv
package epi_pkg;
   // register byte offsets
   localparam logic [7:0] LOWER_SENSE_OFF = 8'h00;
   localparam logic [7:0] UPPER_SENSE_OFF = 8'h04;
   localparam logic [7:0] MASK_OFF        = 8'h08;
   localparam logic [7:0] FLAG_OFF        = 8'h0C;
   localparam logic [7:0] CTRL_OFF        = 8'h10;
   localparam logic [7:0] STATUS_OFF      = 8'h14;
   localparam logic [7:0] IRQ_MASK_OFF    = 8'h18;
   localparam logic [7:0] PIN_OFF         = 8'h1C;
   // ctrl register fields
   localparam int CTRL_GIE_BIT   = 0;
   localparam int CTRL_SLEEP_BIT = 1;
   localparam int CTRL_VACK_BIT  = 2;
   // sticky status fields
   localparam int ST_WAKE_BIT    = 0;
   localparam int ST_FLAG_BIT    = 1;
   // reset values
   localparam logic [7:0] SENSE_RST = 8'h00;
   localparam logic [7:0] MASK_RST  = 8'h00;
   // watchdog oscillator period and start-up time
   localparam int WDT_PERIOD_NS   = 1000;
   localparam int CLK_PERIOD_NS   = 50;
   localparam int WDT_TICK_CYC    = WDT_PERIOD_NS / CLK_PERIOD_NS;
   localparam int STARTUP_TICKS   = 64;
   // sense encodings
   typedef enum logic [1:0] {
      EPI_SENSE_LOW  = 2'b00,
      EPI_SENSE_ANY  = 2'b01,
      EPI_SENSE_FALL = 2'b10,
      EPI_SENSE_RISE = 2'b11
   } epi_sense_t;
   // bus response codes
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ### logic/epi_top.sv
`timescale 1ns/1ps
// Contract
// - pin activity raises interrupts even when the pin is an output
// - each pin triggers on falling edge, rising edge, any change or low level
// - pins 3..0 sense in lower register, pins 7..4 in upper register
// - enabled low-level pin requests continuously while low
// - upper pin edges need the io clock; missed in deep sleep
// - low level wakes device from sleep even with io clock stopped
// - wake level is sampled twice on the watchdog tick
// - wake if level passes double sample or held to start-up end
// - level gone before start-up end: wake, but no interrupt
// - sense field 00 low, 01 change, 10 fall, 11 rise
// - edge sets flag; cleared by handler entry or writing one
// - request forwarded only when mask bit and global enable set
// - upper and lower pins both sampled on clock through the same two-stage synchroniser
module epi_top #(
   parameter int NPINS         = 8,
   parameter int STARTUP_TICKS = epi_pkg::STARTUP_TICKS
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // pins
   input  wire logic [NPINS-1:0]  ext_irq_pins,
   // core side
   input  wire logic              io_clk_run,
   input  wire logic              irq_vec_ack,
   input  wire logic [2:0]        irq_vec_num,
   output logic      [NPINS-1:0]  core_irq_req,
   output logic                   wake_up,
   output logic                   irq,
   // axi4-lite write address
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // axi4-lite write response
   output logic      [1:0]        s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic      [31:0]       s_axi_rdata,
   output logic      [1:0]        s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   logic [NPINS-1:0] sync1_reg, sync2_reg, prev_reg, lvl_mask_reg;
   logic [7:0]       lower_sense_control, upper_sense_control;
   logic [7:0]       ext_irq_mask, ext_irq_flag_reg, aw_addr_reg;
   logic             gie_reg, sleep_reg, wdt_tick, wr_fire, wsamp_reg;
   logic [1:0]       status_reg, irq_mask_reg, st_set;
   logic [4:0]       tick_cnt_reg;
   logic [7:0]       sut_cnt_reg;
   logic             sut_busy_reg;
   logic [NPINS-1:0] hit, low_lvl, clr_flag, lvl_mode, lvl_want;
   logic [31:0]      w_data_reg;
   logic [3:0]       w_strb_reg;

   // pin synchroniser; all stages idle high so release shows no false fall
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         {sync1_reg, sync2_reg, prev_reg} <= '1;
      else
         {prev_reg, sync2_reg, sync1_reg} <=
            {sync2_reg, sync1_reg, ext_irq_pins};
   end

   // per-pin edge/level decode, no port direction gating
   always_comb
   begin
      for (int i = 0; i < NPINS; i++)
      begin
         logic [1:0] sel;
         logic       run;
         sel = (i < 4) ? lower_sense_control[2*i +: 2]
                       : upper_sense_control[2*(i-4) +: 2];
         // upper pins only detect edges while io clock runs
         run = (i < 4) ? 1'b1 : io_clk_run;
         lvl_mode[i] = (sel == epi_pkg::EPI_SENSE_LOW);
         low_lvl[i] = lvl_mode[i] && !sync2_reg[i];
         unique case (sel)
            epi_pkg::EPI_SENSE_LOW:  hit[i] = 1'b0;
            epi_pkg::EPI_SENSE_ANY:  hit[i] = run && (sync2_reg[i] != prev_reg[i]);
            epi_pkg::EPI_SENSE_FALL: hit[i] = run && prev_reg[i] && !sync2_reg[i];
            epi_pkg::EPI_SENSE_RISE: hit[i] = run && !prev_reg[i] && sync2_reg[i];
         endcase
         clr_flag[i] = (irq_vec_ack && irq_vec_num == 3'(i))
                    || (wr_fire && aw_addr_reg == epi_pkg::FLAG_OFF
                        && w_strb_reg[0] && w_data_reg[i]);
      end
   end

   // flags: set beats clear; level-mode pins hold flag at zero
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         ext_irq_flag_reg <= '0;
      else
         ext_irq_flag_reg <= hit | (ext_irq_flag_reg & ~clr_flag & ~lvl_mode);
   end

   // request to core, gated by mask and global enable
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         core_irq_req <= '0;
      else
         // level pins request while low, unless start-up lost level
         core_irq_req <= (ext_irq_flag_reg | (low_lvl & ~lvl_mask_reg))
                         & ext_irq_mask & {NPINS{gie_reg}};
   end

   // watchdog tick divider, about one microsecond
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         tick_cnt_reg <= '0;
      else
         tick_cnt_reg <= wdt_tick ? 5'd0 : tick_cnt_reg + 5'd1;
   end
   assign wdt_tick = (tick_cnt_reg == 5'(epi_pkg::WDT_TICK_CYC - 1));

   // sleep wake: double sample then start-up count
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         wsamp_reg    <= '0;
         sut_busy_reg <= 1'b0;
         sut_cnt_reg  <= '0;
         wake_up      <= 1'b0;
         lvl_mask_reg <= '0;
      end
      else
      begin
         wake_up <= 1'b0;
         if (!sleep_reg)
         begin
            wsamp_reg    <= '0;
            sut_busy_reg <= 1'b0;
            lvl_mask_reg <= '0;
         end
         else if (!sut_busy_reg && wdt_tick)
         begin
            wsamp_reg <= |(low_lvl & ext_irq_mask);
            if (wsamp_reg && |(low_lvl & ext_irq_mask))
            begin
               sut_busy_reg <= 1'b1;
               sut_cnt_reg  <= '0;
            end
         end
         else if (sut_busy_reg && wdt_tick)
         begin
            sut_cnt_reg <= sut_cnt_reg + 8'd1;
            if (sut_cnt_reg == 8'(STARTUP_TICKS - 1))
            begin
               wake_up      <= 1'b1;
               sut_busy_reg <= 1'b0;
               // level gone at end: wake anyway, suppress request
               lvl_mask_reg <= ~(low_lvl & ext_irq_mask) & {NPINS{1'b1}};
            end
         end
      end
   end

   // axi4-lite write channel; readies are flops, low from take to response
   assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_addr_reg   <= '0;
         w_data_reg    <= '0;
         w_strb_reg    <= '0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= epi_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            s_axi_awready <= 1'b0;
            aw_addr_reg   <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            s_axi_wready <= 1'b0;
            w_data_reg   <= s_axi_wdata;
            w_strb_reg   <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_reg > epi_pkg::PIN_OFF
                             || aw_addr_reg[1:0] != 2'b00)
                            ? epi_pkg::RESP_SLVERR : epi_pkg::RESP_OKAY;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // writable registers
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         lower_sense_control <= epi_pkg::SENSE_RST;
         upper_sense_control <= epi_pkg::SENSE_RST;
         ext_irq_mask        <= epi_pkg::MASK_RST;
         gie_reg             <= 1'b0;
         sleep_reg           <= 1'b0;
         irq_mask_reg        <= '0;
      end
      else
      begin
         if (wr_fire && w_strb_reg[0])
            unique case (aw_addr_reg)
               epi_pkg::LOWER_SENSE_OFF: lower_sense_control <= w_data_reg[7:0];
               epi_pkg::UPPER_SENSE_OFF: upper_sense_control <= w_data_reg[7:0];
               epi_pkg::MASK_OFF:        ext_irq_mask <= w_data_reg[7:0];
               epi_pkg::CTRL_OFF:
               begin
                  gie_reg   <= w_data_reg[epi_pkg::CTRL_GIE_BIT];
                  sleep_reg <= w_data_reg[epi_pkg::CTRL_SLEEP_BIT];
               end
               epi_pkg::IRQ_MASK_OFF:    irq_mask_reg <= w_data_reg[1:0];
               default: ;
            endcase
         if (wake_up)
            sleep_reg <= 1'b0;                   // wake ends sleep
      end
   end

   // sticky status: wake and any flag; set beats write-one clear
   assign st_set = {|hit, wake_up};
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         status_reg <= '0;
      else if (wr_fire && aw_addr_reg == epi_pkg::STATUS_OFF && w_strb_reg[0])
         status_reg <= (status_reg & ~w_data_reg[1:0]) | st_set;
      else
         status_reg <= status_reg | st_set;
   end

   // interrupt level output
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         irq <= 1'b0;
      else
         irq <= |(status_reg & irq_mask_reg);
   end

   // read channel, one-cycle answer
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= epi_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= epi_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            epi_pkg::LOWER_SENSE_OFF: s_axi_rdata <= {24'h0, lower_sense_control};
            epi_pkg::UPPER_SENSE_OFF: s_axi_rdata <= {24'h0, upper_sense_control};
            epi_pkg::MASK_OFF:        s_axi_rdata <= {24'h0, ext_irq_mask};
            epi_pkg::FLAG_OFF:        s_axi_rdata <= {24'h0, ext_irq_flag_reg};
            epi_pkg::CTRL_OFF:   s_axi_rdata <= {30'h0, sleep_reg, gie_reg};
            epi_pkg::STATUS_OFF:      s_axi_rdata <= {30'h0, status_reg};
            epi_pkg::IRQ_MASK_OFF:    s_axi_rdata <= {30'h0, irq_mask_reg};
            epi_pkg::PIN_OFF:         s_axi_rdata <= {24'h0, sync2_reg};
            default:
            begin
               s_axi_rdata <= '0;
               s_axi_rresp <= epi_pkg::RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // checks
   flag_set_a: assert property (@(posedge clk) disable iff (reset)
      hit[0] |=> ext_irq_flag_reg[0])
      else $error("flag not set after edge");
   gate_a: assert property (@(posedge clk) disable iff (reset)
      !gie_reg |=> core_irq_req == '0)
      else $error("request without global enable");
   assign lvl_want = low_lvl & ext_irq_mask & ~lvl_mask_reg & {NPINS{gie_reg}};
   level_req_a: assert property (@(posedge clk) disable iff (reset)
      |lvl_want |=> (($past(lvl_want) & ~core_irq_req) == '0))
      else $error("level request missing");
   upper_run_a: assert property (@(posedge clk) disable iff (reset)
      !io_clk_run |-> hit[7:4] == '0)
      else $error("upper edge without io clock");
   fall_a: assert property (@(posedge clk) disable iff (reset)
      (lower_sense_control[1:0] == 2'b10 && prev_reg[0] && !sync2_reg[0])
      |-> hit[0])
      else $error("falling edge missed");
   wake_a: assert property (@(posedge clk) disable iff (reset)
      wake_up |=> !sleep_reg)
      else $error("still asleep after wake");
   double_a: assert property (@(posedge clk) disable iff (reset)
      $rose(sut_busy_reg) |-> wsamp_reg)
      else $error("startup without double sample");
   irq_out_a: assert property (@(posedge clk) disable iff (reset)
      |(status_reg & irq_mask_reg) |=> irq)
      else $error("irq output not raised");
   c_edge: cover property (@(posedge clk) hit[0] && core_irq_req == '0);
   c_wake: cover property (@(posedge clk) wake_up);
   c_lvl:  cover property (@(posedge clk) |(low_lvl & ext_irq_mask));
endmodule

// ### sim/epi_pin_model.sv
`timescale 1ns/1ps
module epi_pin_model (
   // clock
   input  wire logic       clk,
   // pin levels seen by the block
   output logic      [7:0] ext_irq_pins
);
   // idle high like a pulled-up line, so release never looks like a fall
   initial ext_irq_pins = 8'hFF;

   // a level set here may stand for the port output driving the pin
   task automatic drive(input int p, input logic v);
      @(posedge clk);
      ext_irq_pins[p] <= v;
   endtask

   // wake source keeps the low level for the whole span asked for
   task automatic hold_low(input int p, input int cyc);
      drive(p, 1'h0);
      repeat (cyc) @(posedge clk);
      ext_irq_pins[p] <= 1'h1;
   endtask
endmodule

// ### sim/tb_epi_top.sv
`timescale 1ns/1ps
module tb_epi_top;
   // clock, reset and core side
   logic        clk = 1'h0;
   logic        reset = 1'h1;
   logic        io_clk_run = 1'h1;
   logic        irq_vec_ack = 1'h0;
   logic [2:0]  irq_vec_num = 3'h0;
   logic [7:0]  pins;
   logic [7:0]  req;
   logic        wake_up;
   logic        irq;
   // bus
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic        awvalid = 1'h0;
   logic        wvalid = 1'h0;
   logic        bready = 1'h0;
   logic        arvalid = 1'h0;
   logic        rready = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rd;
   logic [1:0]  rsp, wrsp;
   int          error_cnt = 0;
   int          n_tests = 0;

   always #25 clk = ~clk;

   epi_pin_model epi_pin_model_i (.clk(clk), .ext_irq_pins(pins));

   // short start-up keeps the wake tests brief
   epi_top #(.STARTUP_TICKS(4)) epi_top_i (
      .clk(clk), .reset(reset), .ext_irq_pins(pins),
      .io_clk_run(io_clk_run), .irq_vec_ack(irq_vec_ack),
      .irq_vec_num(irq_vec_num), .core_irq_req(req),
      .wake_up(wake_up), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // bus write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do
      begin
         @(posedge clk);
         n++;
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
      end
      while (bvalid !== 1'h1 && n < 50);
      wrsp = bresp;
      bready <= 1'h0;
      chk(32'(bvalid), 32'h1, "write answer");
   endtask

   task automatic rd_reg(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do
      begin
         @(posedge clk);
         n++;
         if (arready === 1'h1) arvalid <= 1'h0;
      end
      while (rvalid !== 1'h1 && n < 50);
      rd = rdata;
      rsp = rresp;
      rready <= 1'h0;
      chk(32'(rvalid), 32'h1, "read answer");
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [31:0] e,
                         input string msg);
      rd_reg(a);
      chk(rd, e, msg);
   endtask

   // whole register written, its other pins fall back to low level
   task automatic set_sense(input int p, input logic [1:0] m);
      wr((p < 4) ? epi_pkg::LOWER_SENSE_OFF : epi_pkg::UPPER_SENSE_OFF,
         32'(m) << (2 * (p % 4)));
   endtask

   task automatic reg_case();
      chk_rd(epi_pkg::LOWER_SENSE_OFF, 32'h0, "lower sense reset");
      chk_rd(epi_pkg::UPPER_SENSE_OFF, 32'h0, "upper sense reset");
      chk_rd(epi_pkg::MASK_OFF, 32'h0, "mask reset");
      wr(epi_pkg::UPPER_SENSE_OFF, 32'hA5);
      chk(32'(wrsp), 32'(epi_pkg::RESP_OKAY), "write resp");
      chk_rd(epi_pkg::UPPER_SENSE_OFF, 32'hA5, "upper sense");
      chk(32'(rsp), 32'(epi_pkg::RESP_OKAY), "read resp");
      wr(8'h20, 32'h0);
      chk(32'(wrsp), 32'(epi_pkg::RESP_SLVERR), "unmapped write resp");
      chk_rd(8'h20, 32'h0, "unmapped data");
      chk(32'(rsp), 32'(epi_pkg::RESP_SLVERR), "unmapped resp");
      $display("test registers done");
   endtask

   task automatic edge_case(input int p, input logic [1:0] m);
      set_sense(p, m);
      wr(epi_pkg::MASK_OFF, 32'h1 << p);
      wr(epi_pkg::FLAG_OFF, 32'hFF);
      wr(epi_pkg::STATUS_OFF, 32'h3);
      epi_pin_model_i.drive(p, 1'h0);
      tick(6);
      chk(32'(req[p]), 32'(m != 2'h3), "request on fall");
      chk(32'(irq), 32'(m != 2'h3), "irq on fall");
      chk_rd(epi_pkg::FLAG_OFF, 32'(m != 2'h3) << p, "fall");
      wr(epi_pkg::FLAG_OFF, 32'h1 << p);
      chk_rd(epi_pkg::FLAG_OFF, 32'h0, "flag write one");
      epi_pin_model_i.drive(p, 1'h1);
      tick(6);
      chk_rd(epi_pkg::FLAG_OFF, 32'(m != 2'h2) << p, "rise");
      // handler entry clears only the acknowledged flag
      @(posedge clk);
      irq_vec_num <= 3'(p);
      irq_vec_ack <= 1'h1;
      @(posedge clk);
      irq_vec_ack <= 1'h0;
      tick(3);
      chk_rd(epi_pkg::FLAG_OFF, 32'h0, "flag after ack");
      $display("test edge pin %0d mode %0d done", p, m);
   endtask

   task automatic level_case();
      set_sense(2, 2'h0);
      wr(epi_pkg::MASK_OFF, 32'h04);
      wr(epi_pkg::CTRL_OFF, 32'h0);
      epi_pin_model_i.drive(2, 1'h0);
      tick(6);
      chk(32'(req[2]), 32'h0, "no global enable");
      wr(epi_pkg::CTRL_OFF, 32'h1);
      tick(4);
      for (int i = 0; i < 8; i++)
      begin
         chk(32'(req[2]), 32'h1, "level held");
         tick(1);
      end
      chk_rd(epi_pkg::FLAG_OFF, 32'h0, "flag in level mode");
      wr(epi_pkg::MASK_OFF, 32'h0);
      tick(4);
      chk(32'(req[2]), 32'h0, "masked level");
      epi_pin_model_i.drive(2, 1'h1);
      $display("test level done");
   endtask

   task automatic ioclk_case();
      @(posedge clk);
      io_clk_run <= 1'h0;
      wr(epi_pkg::UPPER_SENSE_OFF, 32'h20);
      wr(epi_pkg::LOWER_SENSE_OFF, 32'h08);
      wr(epi_pkg::IRQ_MASK_OFF, 32'h0);
      wr(epi_pkg::FLAG_OFF, 32'hFF);
      wr(epi_pkg::STATUS_OFF, 32'h3);
      epi_pin_model_i.drive(6, 1'h0);
      epi_pin_model_i.drive(1, 1'h0);
      tick(6);
      chk_rd(epi_pkg::FLAG_OFF, 32'h02, "io clock stopped");
      chk(32'(irq), 32'h0, "irq masked");
      chk_rd(epi_pkg::STATUS_OFF, 32'h2, "edge status");
      epi_pin_model_i.drive(6, 1'h1);
      epi_pin_model_i.drive(1, 1'h1);
      io_clk_run <= 1'h1;
      wr(epi_pkg::FLAG_OFF, 32'hFF);
      $display("test io clock done");
   endtask

   // hold pin 1 low for the span given while asleep with io clock stopped
   task automatic wake_case(input int hold, input logic ew, input logic er);
      logic w;
      w = 1'h0;
      wr(epi_pkg::LOWER_SENSE_OFF, 32'h0);
      wr(epi_pkg::MASK_OFF, 32'h02);
      wr(epi_pkg::STATUS_OFF, 32'h3);
      io_clk_run <= 1'h0;
      wr(epi_pkg::CTRL_OFF, 32'h3);
      fork
         epi_pin_model_i.hold_low(1, hold);
      join_none
      for (int n = 0; n < 300 && !w; n++)
      begin
         @(posedge clk);
         w = (wake_up === 1'h1);
      end
      tick(2);
      chk(32'(w), 32'(ew), "wake");
      chk(32'(req[1]), 32'(er), "request after wake");
      rd_reg(epi_pkg::STATUS_OFF);
      chk(rd & 32'h1, 32'(ew), "wake status");
      wait fork;
      io_clk_run <= 1'h1;
      wr(epi_pkg::CTRL_OFF, 32'h1);
      $display("test wake hold %0d done", hold);
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      tick(5);
      reset <= 1'h0;
      reg_case();
      wr(epi_pkg::CTRL_OFF, 32'h1);
      wr(epi_pkg::IRQ_MASK_OFF, 32'h2);
      for (int i = 0; i < 6; i++)
         edge_case((i < 3) ? 0 : 5, 2'(i % 3 + 1));
      level_case();
      ioclk_case();
      wake_case(5, 1'h0, 1'h0);
      wake_case(400, 1'h1, 1'h1);
      wake_case(70, 1'h1, 1'h0);
      wrap_up();
   end

   // watchdog well beyond the roughly 1300 cycles the tests need
   initial
   begin
      tick(20000);
      error_cnt++;
      $display("mismatch at %0t: run did not finish", $time);
      wrap_up();
   end
endmodule
